// ==== rtl/twi_rx_fifo.sv ====
// synchronous fifo between byte assembly and the reader
// assumes one clock; in_ready low stalls the writer
`default_nettype none
module twi_rx_fifo
   import twi_rx_pkg::*;
#(
   parameter int WIDTH = FIFO_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [AW:0] wr; // write pointer, extra wrap bit
      logic [AW:0] rd; // read pointer
      logic [AW:0] fill; // words held
   } fifo_state_type;

   fifo_state_type s_r; // registered state
   fifo_state_type s_nxt; // next state
   logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset needed
   logic do_wr; // accepted write
   logic do_rd; // accepted read

   // honest flags straight from the fill count
   assign in_ready = (s_r.fill != DEPTH_C);
   assign out_valid = (s_r.fill != '0);
   assign out_data = mem[s_r.rd[AW-1:0]];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   // pointer and count update
   always_comb begin
      s_nxt = s_r;
      if (do_wr) begin
         s_nxt.wr = (s_r.wr[AW-1:0] == AW'(DEPTH - 1)) ? {~s_r.wr[AW], {AW{1'b0}}}
                                                        : s_r.wr + 1'b1;
      end
      if (do_rd) begin
         s_nxt.rd = (s_r.rd[AW-1:0] == AW'(DEPTH - 1)) ? {~s_r.rd[AW], {AW{1'b0}}}
                                                        : s_r.rd + 1'b1;
      end
      // simultaneous read and write leaves the count alone
      if (do_wr && !do_rd) begin
         s_nxt.fill = s_r.fill + 1'b1;
      end else if (do_rd && !do_wr) begin
         s_nxt.fill = s_r.fill - 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // storage write
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[s_r.wr[AW-1:0]] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/twi_rx_path.sv ====
// two-wire receive path: pin roles, line defaults, filters, condition
// detect, receive buffer with split store, dma source and byte fifo
// assumes pin inputs synchronous to clk and an outside pad resolving
// the open-drain wires from the active-low enables
`default_nettype none
module twi_rx_path
   import twi_rx_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic two_wire_mode_select,
   input wire logic [2:0] serial_mode_select,
   input wire logic ack_interrupt_select,
   input wire logic clock_delay_select,
   input wire logic clock_polarity_select,
   input wire logic port_output_data,
   input wire logic port_direction,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe_n,
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe_n,
   output logic serial_clock_level,
   output logic serial_data_level,
   output logic [8:0] receive_buffer_reg,
   output logic [7:0] receive_read_data,
   output logic dma_request,
   output logic nack_interrupt,
   output logic start_detect,
   output logic stop_detect,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data
);
   typedef struct packed {
      phase_type ph; // frame phase
      logic [3:0] cnt; // clock rising edges in this byte
      logic [7:0] shreg; // incoming bits, first in at top
      logic [8:0] rbuf; // receive buffer
      logic split; // buffer currently holds split layout
      logic push_pend; // byte waiting for the fifo
      logic [7:0] push_data; // byte to push
      logic dflt; // latched data line default
      logic sda_f; // filtered data
      logic scl_f; // filtered clock
      logic sda_q; // previous filtered data
      logic scl_q; // previous filtered clock
      logic [2:0] sda_cnt; // data filter stability count
      logic [2:0] scl_cnt; // clock filter stability count
      logic start_p; // start pulse
      logic stop_p; // stop pulse
      logic dma_p; // dma request pulse
      logic nack_p; // nack pulse
   } path_state_type;

   path_state_type s_r; // registered state
   path_state_type s_nxt; // next state
   logic mode_on; // two-wire mode active
   logic [2:0] filt_len; // filter width in cycles
   logic scl_rise; // filtered clock rising
   logic scl_fall; // filtered clock falling
   logic split_mode; // split-byte layout in force
   logic fifo_in_ready; // fifo can take a byte
   logic stretch; // hold clock low for back-pressure
   logic scl_drive_low; // clock pull-down request

   assign mode_on = two_wire_mode_select && (serial_mode_select == SMD_TWO_WIRE);
   assign filt_len = mode_on ? FILT_WIDE_CYC : FILT_NARROW_CYC;
   assign scl_rise = s_r.scl_f && !s_r.scl_q;
   assign scl_fall = !s_r.scl_f && s_r.scl_q;
   assign split_mode = ack_interrupt_select && clock_delay_select;

   // a full fifo stretches the clock so the sender waits, not the data lost
   assign stretch = mode_on && s_r.push_pend && !fifo_in_ready;
   // idle clock level follows the delay setting; stretch pulls low
   assign scl_drive_low = mode_on && ((clock_delay_select && s_r.ph == PH_IDLE) || stretch);

   // open drain: drive only a low, release for a high
   assign serial_clock_pin_out = 1'b0;
   assign serial_clock_pin_oe_n = !scl_drive_low;
   assign serial_data_pin_out = 1'b0;
   assign serial_data_pin_oe_n = s_r.dflt;

   // clock level visible in two-wire mode whatever the direction bit
   assign serial_clock_level = (mode_on || !port_direction) ? s_r.scl_f : 1'b0;
   assign serial_data_level = (mode_on || !port_direction) ? s_r.sda_f : 1'b0;

   assign receive_buffer_reg = s_r.rbuf;
   // split layout reads back as a whole byte
   assign receive_read_data = s_r.split ? {s_r.rbuf[6:0], s_r.rbuf[SPLIT_HI_BIT]}
                                        : s_r.rbuf[7:0];
   assign dma_request = s_r.dma_p;
   assign nack_interrupt = s_r.nack_p;
   assign start_detect = s_r.start_p;
   assign stop_detect = s_r.stop_p;

   // next-state logic for the whole path
   always_comb begin
      s_nxt = s_r;
      s_nxt.start_p = 1'b0;
      s_nxt.stop_p = 1'b0;
      s_nxt.dma_p = 1'b0;
      s_nxt.nack_p = 1'b0;
      s_nxt.sda_q = s_r.sda_f;
      s_nxt.scl_q = s_r.scl_f;

      // default data level only latched while serial i/o is disabled
      if (serial_mode_select == SMD_DISABLED) begin
         s_nxt.dflt = port_output_data;
      end

      // glitch filters: accept a new level after filt_len stable cycles
      if (serial_data_pin_in == s_r.sda_f) begin
         s_nxt.sda_cnt = 3'h0;
      end else if (s_r.sda_cnt + 3'h1 >= filt_len) begin
         s_nxt.sda_f = serial_data_pin_in;
         s_nxt.sda_cnt = 3'h0;
      end else begin
         s_nxt.sda_cnt = s_r.sda_cnt + 3'h1;
      end
      if (serial_clock_pin_in == s_r.scl_f) begin
         s_nxt.scl_cnt = 3'h0;
      end else if (s_r.scl_cnt + 3'h1 >= filt_len) begin
         s_nxt.scl_f = serial_clock_pin_in;
         s_nxt.scl_cnt = 3'h0;
      end else begin
         s_nxt.scl_cnt = s_r.scl_cnt + 3'h1;
      end

      // fifo accepted the pending byte
      if (s_r.push_pend && fifo_in_ready) begin
         s_nxt.push_pend = 1'b0;
      end

      if (!mode_on) begin
         // leaving the mode drops any half-received frame
         s_nxt.ph = PH_IDLE;
         s_nxt.cnt = 4'h0;
      end else if (s_r.scl_f && s_r.scl_q && s_r.sda_q && !s_r.sda_f) begin
         // data falls with clock high
         s_nxt.start_p = 1'b1;
         s_nxt.ph = PH_SHIFT;
         s_nxt.cnt = 4'h0;
      end else if (s_r.scl_f && s_r.scl_q && !s_r.sda_q && s_r.sda_f) begin
         // data rises with clock high
         s_nxt.stop_p = 1'b1;
         s_nxt.ph = PH_IDLE;
         s_nxt.cnt = 4'h0;
      end else begin
         case (s_r.ph)
            PH_IDLE: begin
               // wait for a start condition
               s_nxt.cnt = 4'h0;
            end
            PH_SHIFT: begin
               // data bits sampled on clock rising, first bit ends at top
               if (scl_rise) begin
                  s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_f};
                  s_nxt.cnt = s_r.cnt + 4'h1;
                  if (s_r.cnt + 4'h1 == DATA_BITS) begin
                     s_nxt.ph = PH_NINTH;
                  end
               end
            end
            PH_NINTH: begin
               if (scl_rise && s_r.cnt == DATA_BITS) begin
                  // ninth rising: acknowledge bit seen
                  s_nxt.cnt = ACK_BIT;
                  if (!ack_interrupt_select && s_r.sda_f) begin
                     s_nxt.nack_p = 1'b1;
                  end
                  if (!ack_interrupt_select && !s_r.sda_f) begin
                     s_nxt.dma_p = 1'b1;
                  end
               end else if (scl_fall && s_r.cnt == ACK_BIT) begin
                  // ninth falling: first buffer transfer
                  s_nxt.cnt = 4'h0;
                  if (ack_interrupt_select) begin
                     s_nxt.dma_p = 1'b1;
                  end
                  if (split_mode) begin
                     // bits one to seven low, eighth parked in bit 8
                     s_nxt.rbuf = {s_r.shreg[0], 1'b0, s_r.shreg[7:1]};
                     s_nxt.split = 1'b1;
                     s_nxt.ph = PH_SECOND;
                  end else begin
                     s_nxt.rbuf = {1'b0, s_r.shreg};
                     s_nxt.split = 1'b0;
                     s_nxt.push_pend = 1'b1;
                     s_nxt.push_data = s_r.shreg;
                     s_nxt.ph = PH_SHIFT;
                  end
               end
            end
            PH_SECOND: begin
               // delayed ninth rising: full byte rewritten in place
               if (scl_rise) begin
                  s_nxt.rbuf = {1'b0, s_r.shreg};
                  s_nxt.split = 1'b0;
                  s_nxt.push_pend = 1'b1;
                  s_nxt.push_data = s_r.shreg;
                  s_nxt.ph = PH_SHIFT;
                  s_nxt.cnt = 4'h0;
               end
            end
            default: begin
               s_nxt.ph = PH_IDLE;
               s_nxt.cnt = 4'h0;
            end
         endcase
      end
   end

   // state register; lines assumed released high at reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.ph <= PH_IDLE;
         s_r.rbuf <= RBUF_RESET;
         s_r.dflt <= 1'b1;
         s_r.sda_f <= 1'b1;
         s_r.scl_f <= 1'b1;
         s_r.sda_q <= 1'b1;
         s_r.scl_q <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // received bytes queue here; full stretches the clock
   twi_rx_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(s_r.push_pend),
      .in_ready(fifo_in_ready),
      .in_data(s_r.push_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   // polarity select has no effect on the two-wire lines
   logic unused_pol;
   assign unused_pol = clock_polarity_select;
endmodule
`default_nettype wire

// ==== rtl/twi_rx_pkg.sv ====
// constants and types shared by the two-wire receive path and its fifo
// assumes a 20 MHz peripheral clock and pins synchronous to it
// How it works
// - transmit pin becomes two-way data line
// - receive pin becomes two-way clock line
// - clock pin level readable regardless of direction
// - data line idles at port output value
// - dma source: ack, or ninth falling edge
// - normal store: bits one-eight into 7..0
// - split store: bits 6..0, eighth in 8
// - first transfer on ninth clock falling edge
// - split: second transfer rewrites full byte
// - split read: 6..0 as 7..1, 8 as 0
// - start: data falls while clock high
// - stop: data rises while clock high
// - nack interrupt on ninth rising edge
`default_nettype none
package twi_rx_pkg;
   // serial mode field encodings
   localparam logic [2:0] SMD_DISABLED = 3'h0;
   localparam logic [2:0] SMD_TWO_WIRE = 3'h2;
   // clock and filter times
   localparam int CLK_PERIOD_NS = 50;
   localparam int FILT_WIDE_NS = 200;
   localparam int FILT_NARROW_NS = 15;
   // a least time rounds up, never below one cycle
   localparam int FILT_WIDE_INT = (FILT_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_NARROW_INT = (FILT_NARROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] FILT_WIDE_CYC = 3'(FILT_WIDE_INT < 1 ? 1 : FILT_WIDE_INT);
   localparam logic [2:0] FILT_NARROW_CYC = 3'(FILT_NARROW_INT < 1 ? 1 : FILT_NARROW_INT);
   // bit positions of a byte frame
   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [3:0] ACK_BIT = 4'h9;
   // receive buffer layout
   localparam int RBUF_W = 9;
   localparam int SPLIT_HI_BIT = 8;
   localparam logic [8:0] RBUF_RESET = 9'h000;
   // fifo defaults
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 8;
   // frame phase, gray along idle -> shift -> ninth -> second
   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_SHIFT = 2'h1,
      PH_NINTH = 2'h3,
      PH_SECOND = 2'h2
   } phase_type;
endpackage
`default_nettype wire

// ==== sim/tb_twi_rx_path.sv ====
// self-checking bench for the two-wire receive path
// assumes the peer model on the wires and the checker bound to the design
`default_nettype none
module tb_twi_rx_path
   import twi_rx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, two_wire_mode_select, ack_interrupt_select, clock_delay_select;
   logic clock_polarity_select, port_output_data, port_direction, rx_ready;
   logic [2:0] serial_mode_select;
   logic serial_data_pin_oe_n, serial_clock_pin_oe_n, serial_clock_level, dma_request;
   logic serial_data_level; // filtered data level as software reads it
   logic nack_interrupt, start_detect, stop_detect, rx_valid, sda_low, scl_low;
   logic [8:0] receive_buffer_reg;
   logic [7:0] receive_read_data, rx_data;
   wire logic sda, scl; // pulled up unless someone pulls low
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int cnt[4] = '{0, 0, 0, 0}; // dma, nack, start, stop pulses seen
   logic [7:0] exp_q[$]; // bytes owed by the fifo
   assign sda = !(sda_low || !serial_data_pin_oe_n);
   assign scl = !(scl_low || !serial_clock_pin_oe_n);
   twi_rx_path i_dut (.clk, .rst_n, .two_wire_mode_select, .serial_mode_select,
      .ack_interrupt_select, .clock_delay_select, .clock_polarity_select, .port_output_data,
      .port_direction, .serial_data_pin_in(sda), .serial_data_pin_out(), .serial_data_pin_oe_n,
      .serial_clock_pin_in(scl), .serial_clock_pin_out(), .serial_clock_pin_oe_n,
      .serial_clock_level, .serial_data_level, .receive_buffer_reg, .receive_read_data,
      .dma_request, .nack_interrupt, .start_detect, .stop_detect, .rx_valid, .rx_ready, .rx_data);
   twi_peer i_peer (.clk, .scl, .sda_low, .scl_low);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic print_verdict();
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // pulse counts and the hang limit
   always @(posedge clk) begin
      cycles++;
      if (dma_request === 1'b1) cnt[0]++;
      if (nack_interrupt === 1'b1) cnt[1]++;
      if (start_detect === 1'b1) cnt[2]++;
      if (stop_detect === 1'b1) cnt[3]++;
      if (cycles == 40000) begin
         fail_count++;
         print_verdict();
      end
   end
   // buffer after the ninth falling edge
   function automatic logic [8:0] exp_buf(input logic [7:0] b);
      return (ack_interrupt_select && clock_delay_select) ? {b[0], 1'b0, b[7:1]} : {1'b0, b};
   endfunction
   // pulses owed by one framed byte: dma, nack, start, stop
   function automatic logic [8:0] exp_cnt(input int i, input logic ack);
      if (i == 0) return 9'(ack_interrupt_select || !ack);
      if (i == 1) return 9'(!ack_interrupt_select && ack);
      return 9'h001;
   endfunction
   task automatic frame(input logic [7:0] b, input logic ack, input logic dly);
      int c0[4];
      c0 = cnt;
      i_peer.start_cond();
      clock_delay_select = dly;
      i_peer.send_byte(b, ack);
      check(receive_buffer_reg, exp_buf(b));
      check({1'b0, receive_read_data}, {1'b0, b});
      i_peer.stop_cond();
      check(receive_buffer_reg, {1'b0, b});
      for (int i = 0; i < 4; i++)
         check(9'(cnt[i] - c0[i]), exp_cnt(i, ack));
      exp_q.push_back(b);
   endtask
   task automatic pop();
      repeat (100) if (rx_valid !== 1'b1) @(negedge clk);
      check({1'b0, rx_data}, {1'b0, exp_q.pop_front()});
      rx_ready = 1'b1;
      @(negedge clk);
      rx_ready = 1'b0;
      // one idle cycle so a following pop never rewrites ready in this step
      @(negedge clk);
   endtask
   initial begin
      {two_wire_mode_select, ack_interrupt_select, clock_delay_select} = 3'h0;
      clock_polarity_select = 1'b0;
      serial_mode_select = SMD_DISABLED;
      port_output_data = 1'b1;
      port_direction = 1'b1;
      rx_ready = 1'b0;
      rst_n = 1'b0;
      void'($urandom(78043));
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      port_output_data = 1'b0;
      repeat (3) @(negedge clk);
      check(serial_data_pin_oe_n, 1'b0);
      check(serial_clock_level, 1'b0);
      port_output_data = 1'b1;
      repeat (3) @(negedge clk);
      check(serial_data_pin_oe_n, 1'b1);
      serial_mode_select = SMD_TWO_WIRE;
      two_wire_mode_select = 1'b1;
      port_output_data = 1'b0;
      repeat (10) @(negedge clk);
      check(serial_data_pin_oe_n, 1'b1);
      check(serial_clock_level, 1'b1);
      check(serial_data_level, 1'b1);
      check(serial_clock_pin_oe_n, 1'b1);
      for (int m = 0; m < 16; m++) begin
         // source only changes between frames, with no pulse pending
         ack_interrupt_select = m[1];
         clock_polarity_select = 1'($urandom);
         port_direction = 1'($urandom);
         i_peer.h = 8 + $urandom % 6;
         frame((m < 2) ? {8{m[0]}} : 8'($urandom), m[2], m[0]);
         if (m[0]) begin
            check(serial_clock_pin_oe_n, 1'b0);
            clock_delay_select = 1'b0;
            repeat (8) @(negedge clk);
         end
         pop();
      end
      // fill the fifo, then a ninth byte must stretch the clock
      ack_interrupt_select = 1'b0;
      for (int n = 0; n < 8; n++)
         frame(8'($urandom), 1'b0, 1'b0);
      check(rx_valid, 1'b1);
      fork
         frame(8'h5a, 1'b0, 1'b0);
         begin
            repeat (2000) if (serial_clock_pin_oe_n !== 1'b0) @(negedge clk);
            check(serial_clock_pin_oe_n, 1'b0);
            repeat (8) pop();
         end
      join
      pop();
      check(rx_valid, 1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire

// ==== sim/twi_peer.sv ====
// bus controller model: start, byte, ack bit and stop on the two wires
// assumes the bench resolves the open-drain wires with pull-ups
`default_nettype none
module twi_peer (
   input wire logic clk,
   input wire logic scl, // resolved clock wire
   output logic sda_low, // pulls the data wire low
   output logic scl_low // pulls the clock wire low
);
   timeunit 1ns;
   timeprecision 1ns;
   int h = 8; // half phase in clocks, prompt or slow
   initial begin
      sda_low = 1'b0;
      scl_low = 1'b0;
   end
   // release clock, honour a stretch; bounded so a stuck wire cannot hang
   task automatic rise();
      scl_low = 1'b0;
      repeat (2000) if (scl !== 1'b1) @(negedge clk);
      repeat (h) @(negedge clk);
   endtask
   // data falls while clock high
   task automatic start_cond();
      sda_low = 1'b1;
      repeat (h) @(negedge clk);
      scl_low = 1'b1;
      repeat (h) @(negedge clk);
   endtask
   // data only moves while clock is low
   task automatic put_bit(input logic v);
      sda_low = !v;
      repeat (h) @(negedge clk);
      rise();
      scl_low = 1'b1;
      repeat (h) @(negedge clk);
   endtask
   // msb first, ninth bit carries the ack level
   task automatic send_byte(input logic [7:0] b, input logic ack);
      for (int i = 7; i >= 0; i--)
         put_bit(b[i]);
      put_bit(ack);
   endtask
   // data rises while clock high
   task automatic stop_cond();
      sda_low = 1'b1;
      repeat (h) @(negedge clk);
      rise();
      sda_low = 1'b0;
      repeat (h) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// ==== sim/twi_rx_path_sva.sv ====
// checker for the two-wire receive path, port relations only
// assumes binding onto twi_rx_path with pins synchronous to clk
`default_nettype none
module twi_rx_path_sva
   import twi_rx_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic two_wire_mode_select,
   input wire logic [2:0] serial_mode_select,
   input wire logic ack_interrupt_select,
   input wire logic clock_delay_select,
   input wire logic port_output_data,
   input wire logic serial_data_pin_oe_n,
   input wire logic serial_clock_pin_oe_n,
   input wire logic serial_clock_level,
   input wire logic serial_data_level,
   input wire logic [8:0] receive_buffer_reg,
   input wire logic dma_request,
   input wire logic nack_interrupt,
   input wire logic start_detect,
   input wire logic stop_detect
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic mode_on; // both mode fields agree
   assign mode_on = two_wire_mode_select && (serial_mode_select == SMD_TWO_WIRE);
   chk_start_cond: assert property (start_detect |-> serial_clock_level && !serial_data_level)
      else $error("start flagged without clock high and data low");
   chk_stop_cond: assert property (stop_detect |-> serial_clock_level && serial_data_level)
      else $error("stop flagged without clock and data high");
   chk_pulse_single: assert property (start_detect || stop_detect |=> !start_detect && !stop_detect)
      else $error("condition pulse longer than one cycle");
   chk_clock_release: assert property (!mode_on [*2] |-> serial_clock_pin_oe_n)
      else $error("clock driven outside two-wire mode");
   chk_data_default: assert property (serial_mode_select == SMD_DISABLED |=> serial_data_pin_oe_n == $past(port_output_data))
      else $error("data default not taken from port output");
   chk_split_bit: assert property (receive_buffer_reg[8] |-> ack_interrupt_select && clock_delay_select)
      else $error("buffer bit 8 set outside split store");
   chk_first_fall: assert property ($changed(receive_buffer_reg) && !clock_delay_select |-> !serial_clock_level)
      else $error("buffer written while clock high");
   chk_nack_rise: assert property (nack_interrupt |-> !ack_interrupt_select && serial_clock_level && serial_data_level)
      else $error("nack without high ninth bit");
   chk_dma_ack: assert property (dma_request && !ack_interrupt_select |-> serial_clock_level && !serial_data_level)
      else $error("dma without ack detection");
   chk_dma_fall: assert property (dma_request && ack_interrupt_select |-> !serial_clock_level)
      else $error("dma not on ninth falling edge");
endmodule
bind twi_rx_path twi_rx_path_sva i_sva (.clk, .rst_n, .two_wire_mode_select, .serial_mode_select,
   .ack_interrupt_select, .clock_delay_select, .port_output_data, .serial_data_pin_oe_n,
   .serial_clock_pin_oe_n, .serial_clock_level, .serial_data_level, .receive_buffer_reg,
   .dma_request, .nack_interrupt, .start_detect, .stop_detect);
`default_nettype wire
